// ### verilog/rscg_pkg.sv
// constants and types of the reset sequencer and clock guard
package rscg_pkg;
  // timing
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          RST_OUT_MIN_NS  = 20000;
  localparam logic [11:0] RST_OUT_LAST    =
    12'((RST_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
  localparam int          STAB_CYC        = 4096;
  localparam logic [11:0] STAB_LAST       = 12'(STAB_CYC - 1);
  localparam int          SPIKE_GAP_NS    = 50;
  localparam logic [5:0]  SPIKE_GAP_CYC   =
    6'((SPIKE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          CLK_LOSS_NS     = 1000;
  localparam logic [5:0]  CLK_LOSS_CYC    = 6'(CLK_LOSS_NS / CLK_PERIOD_NS);
  localparam logic [4:0]  RECOVER_LAST    = 5'h0f;
  localparam int          PIN_SYNC_DEPTH  = 2;
  // reset vector
  localparam logic [15:0] VEC_ADDR_LO     = 16'hfffe;
  localparam logic [15:0] VEC_ADDR_HI     = 16'hffff;
  // register map
  localparam logic [7:0]  REG_FLAGS       = 8'h00;
  localparam logic [7:0]  REG_STATE       = 8'h04;
  localparam int          FLD_WDG         = 0;
  localparam int          FLD_BACKUP      = 1;
  localparam int          FLD_GUARD_IE    = 2;
  localparam int          FLD_LVD         = 4;
  localparam logic [1:0]  THR_LEVEL_MAX   = 2'h2;
  typedef enum logic [1:0] {
    PH_RUN   = 2'b00,
    PH_DELAY = 2'b01,
    PH_STAB  = 2'b10,
    PH_FETCH = 2'b11
  } rscg_phase_e;
  typedef enum logic [2:0] {
    OSC_EXT   = 3'b000,
    OSC_RES0  = 3'b001,
    OSC_RES1  = 3'b010,
    OSC_RES2  = 3'b011,
    OSC_RES3  = 3'b100,
    OSC_EXTRC = 3'b101,
    OSC_INTRC = 3'b110
  } rscg_osc_e;
endpackage

// ### verilog/rscg_clk_if.sv
// signals between the sequencer and the clock filter
interface rscg_clk_if;
  logic oscEdge;
  logic guardEn;
  logic blockMain;
  logic backupActive;
  modport filt (input oscEdge, input guardEn, output blockMain, output backupActive);
  modport ctl  (output oscEdge, output guardEn, input blockMain, input backupActive);
endinterface

// ### verilog/rscg_pin_sync.sv
// two-stage synchroniser for the reset pin level
module rscg_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // level
  input  wire logic pinIn,
  output logic      pinSync
);
  typedef struct packed {
    logic [rscg_pkg::PIN_SYNC_DEPTH-1:0] stage;
  } rscg_sync_s;
  rscg_sync_s q, d;
  always_comb begin
    d.stage = {q.stage[0], pinIn};
    if (sys_rst) begin
      d.stage = '1;
    end
  end
  always_ff @(posedge clk) begin
    q <= d;
  end
  assign pinSync = q.stage[rscg_pkg::PIN_SYNC_DEPTH-1];
endmodule // rscg_pin_sync

// ### verilog/rscg_clk_filter.sv
// clock filter and backup clock takeover
module rscg_clk_filter (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // clock monitor
  rscg_clk_if.filt  cf
);
  typedef struct packed {
    logic [5:0] gap;
    logic [4:0] good;
    logic       block;
    logic       backup;
  } rscg_filt_s;
  rscg_filt_s q, d;
  always_comb begin
    d = q;
    if (!cf.guardEn || sys_rst) begin
      d = '0;
    end else if (cf.oscEdge) begin
      d.gap = '0;
      if (q.gap < rscg_pkg::SPIKE_GAP_CYC) begin
        d.block  = 1'b1;
        d.backup = 1'b1;
        d.good   = '0;
      end else if (q.good == rscg_pkg::RECOVER_LAST) begin
        d.block  = 1'b0;
        d.backup = 1'b0;
      end else begin
        d.good = q.good + 5'h01;
      end
    end else if (q.gap != rscg_pkg::CLK_LOSS_CYC) begin
      d.gap = q.gap + 6'h01;
    end else begin
      d.backup = 1'b1;
      d.good   = '0;
    end
  end
  always_ff @(posedge clk) begin
    q <= d;
  end
  assign cf.blockMain    = q.block;
  assign cf.backupActive = q.backup;
  a_spike_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    (cf.guardEn && cf.oscEdge && q.gap < rscg_pkg::SPIKE_GAP_CYC) |=> q.block)
    else $error("spike did not block main clock");
  a_guard_off_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !cf.guardEn |=> !q.block && !q.backup)
    else $error("filter active while guard disabled");
endmodule // rscg_clk_filter

// ### verilog/reset_sequence_clock_guard.sv
// reset sequencer, supply drop detector, oscillator selector and clock guard
// Contract
// - supply below reference holds static reset
// - rising threshold up, falling threshold down
// - supply drop reset drives reset pin low
// - option picks one of three thresholds
// - supply drop sets flag, write zero clears
// - pin, supply, watchdog start reset, pin low
// - delay, 4096 stabilisation cycles, vector fetch
// - full 4096 count before execution
// - two-cycle fetch from FFFE then FFFF
// - reset pin input plus open-drain output
// - external low level detected at any time; not while the pin is driven by us nor for three cycles after
// - recognised external reset drives pin minimum time
// - watchdog underflow drives pin minimum time
// - option selects one of seven clock sources
// - resonators keep running during reset
// - option enables or disables clock guard
// - filter blocks spikes or whole clock; on clock loss the filter only selects backup and leaves blockMain unchanged
// - filter releases when clock valid again
// - backup clock takes over, switches back
// - watchdog flag, cleared by write or supply
// - supply flag survives later resets
module reset_sequence_clock_guard (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset pin, open drain
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  // supply comparators
  input  wire logic        supplyAboveRise,
  input  wire logic        supplyAboveFall,
  output logic      [1:0]  thresholdSel,
  // options
  input  wire logic [1:0]  optThreshold,
  input  wire logic [2:0]  optOscSource,
  input  wire logic        optGuardEn,
  // watchdog and main clock monitor
  input  wire logic        wdgUnderflow,
  input  wire logic        oscEdge,
  // clock control
  output logic      [2:0]  oscSelect,
  output logic             oscRun,
  output logic             blockMain,
  output logic             backupClkSel,
  // cpu side
  output logic             cpuRst,
  output logic             vectorFetch,
  output logic      [15:0] vectorAddr
);
  typedef struct packed {
    rscg_pkg::rscg_phase_e phase;
    logic [11:0]           cnt;
    logic                  supplyOk;
    logic                  lvdFlag;
    logic                  wdgFlag;
    logic                  backupFlag;
    logic                  guardIe;
    logic                  pinOe;
    logic                  pinOut;
    logic [2:0]            pinMask;
    logic                  cpuRst;
    logic                  fetch;
    logic [15:0]           vecAddr;
    logic [1:0]            thrSel;
    rscg_pkg::rscg_osc_e   oscSel;
    logic                  guardEn;
    logic                  oscRun;
    logic                  blockMain;
    logic                  backupActive;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } rscg_state_s;

  rscg_state_s q, d;
  logic        pinSync;
  logic        pinReq;
  logic        anySrc;
  logic        apbAccess;
  logic        apbDone;

  rscg_clk_if cf ();

  // external reset level into clock domain
  rscg_pin_sync u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (resetPinIn),
    .pinSync (pinSync)
  );

  rscg_clk_filter u_clk_filter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cf      (cf.filt)
  );

  assign cf.oscEdge = oscEdge;
  assign cf.guardEn = q.guardEn;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  function automatic logic [31:0] flags_word(input rscg_state_s s);
    logic [31:0] w;
    w = '0;
    w[rscg_pkg::FLD_LVD]      = s.lvdFlag;
    w[rscg_pkg::FLD_GUARD_IE] = s.guardIe;
    w[rscg_pkg::FLD_BACKUP]   = s.backupFlag & s.guardEn;
    w[rscg_pkg::FLD_WDG]      = s.wdgFlag;
    return w;
  endfunction

  // pin low that we are not driving ourselves
  assign pinReq    = !pinSync && !q.pinOe && (q.pinMask == 3'h0);
  assign anySrc    = !q.supplyOk || wdgUnderflow || pinReq;
  assign apbAccess = psel && penable;
  assign apbDone   = apbAccess && q.pready;

  always_comb begin
    d = q;
    d.pinOut  = 1'b0;
    d.pinMask = {q.pinMask[1:0], q.pinOe};
    d.oscRun  = 1'b1;
    d.pready  = apbAccess && !q.pready;
    d.pslverr = 1'b0;
    d.blockMain    = cf.blockMain;
    d.backupActive = cf.backupActive;

    // supply drop detector with hysteresis
    if (q.supplyOk) begin
      d.supplyOk = supplyAboveFall;
    end else begin
      d.supplyOk = supplyAboveRise;
    end

    // reset sequence
    unique case (q.phase)
      rscg_pkg::PH_RUN: begin
        d.cpuRst = 1'b0;
        d.fetch  = 1'b0;
      end
      rscg_pkg::PH_DELAY: begin
        d.pinOe  = 1'b1;
        d.cpuRst = 1'b1;
        if (q.cnt != rscg_pkg::RST_OUT_LAST) begin
          d.cnt = q.cnt + 12'h001;
        end else if (q.supplyOk) begin
          d.phase = rscg_pkg::PH_STAB;
          d.cnt   = '0;
          d.pinOe = 1'b0;
        end
      end
      rscg_pkg::PH_STAB: begin
        d.cpuRst = 1'b1;
        if (q.cnt != rscg_pkg::STAB_LAST) begin
          d.cnt = q.cnt + 12'h001;
        end else begin
          d.phase   = rscg_pkg::PH_FETCH;
          d.cnt     = '0;
          d.cpuRst  = 1'b0;
          d.fetch   = 1'b1;
          d.vecAddr = rscg_pkg::VEC_ADDR_LO;
        end
      end
      rscg_pkg::PH_FETCH: begin
        if (q.vecAddr == rscg_pkg::VEC_ADDR_LO) begin
          d.vecAddr = rscg_pkg::VEC_ADDR_HI;
        end else begin
          d.phase = rscg_pkg::PH_RUN;
          d.fetch = 1'b0;
        end
      end
    endcase

    // any source restarts the sequence
    if (anySrc) begin
      d.phase  = rscg_pkg::PH_DELAY;
      d.cnt    = '0;
      d.pinOe  = 1'b1;
      d.cpuRst = 1'b1;
      d.fetch  = 1'b0;
    end

    // apb read data and error
    if (apbAccess && !q.pready) begin
      d.pslverr = !is_reg(paddr, rscg_pkg::REG_FLAGS) && !is_reg(paddr, rscg_pkg::REG_STATE);
      d.prdata  = '0;
      if (!pwrite && is_reg(paddr, rscg_pkg::REG_FLAGS)) begin
        d.prdata = flags_word(q);
      end else if (!pwrite && is_reg(paddr, rscg_pkg::REG_STATE)) begin
        d.prdata = {21'h0, q.guardEn, q.thrSel, q.oscSel, q.backupActive,
                    q.blockMain, q.supplyOk, q.phase};
      end
    end

    // software clears, writing zero
    if (apbDone && pwrite && is_reg(paddr, rscg_pkg::REG_FLAGS)) begin
      if (!pwdata[rscg_pkg::FLD_LVD]) begin
        d.lvdFlag = 1'b0;
      end
      if (!pwdata[rscg_pkg::FLD_WDG]) begin
        d.wdgFlag = 1'b0;
      end
      d.guardIe = pwdata[rscg_pkg::FLD_GUARD_IE];
    end
    // backup flag clears on read once main clock is back
    if (apbDone && !pwrite && is_reg(paddr, rscg_pkg::REG_FLAGS) && !q.backupActive) begin
      d.backupFlag = 1'b0;
    end

    // hardware sets win over clears
    if (!q.supplyOk) begin
      d.lvdFlag = 1'b1;
      d.wdgFlag = 1'b0;
    end
    if (wdgUnderflow) begin
      d.wdgFlag = 1'b1;
    end
    if (q.backupActive) begin
      d.backupFlag = 1'b1;
    end

    if (sys_rst) begin
      d          = '0;
      d.phase    = rscg_pkg::PH_DELAY;
      d.cpuRst   = 1'b1;
      d.pinOe    = 1'b1;
      d.oscRun   = 1'b1;
      // start from the comparator so release does not look like a supply drop
      d.supplyOk = supplyAboveRise;
      d.thrSel   = (optThreshold > rscg_pkg::THR_LEVEL_MAX) ?
                   rscg_pkg::THR_LEVEL_MAX : optThreshold;
      d.oscSel   = (optOscSource == 3'h7) ? rscg_pkg::OSC_INTRC :
                   rscg_pkg::rscg_osc_e'(optOscSource);
      d.guardEn  = optGuardEn;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign resetPinOut  = q.pinOut;
  assign resetPinOe   = q.pinOe;
  assign thresholdSel = q.thrSel;
  assign oscSelect    = q.oscSel;
  assign oscRun       = q.oscRun;
  assign blockMain    = q.blockMain;
  assign backupClkSel = q.backupActive;
  assign cpuRst       = q.cpuRst;
  assign vectorFetch  = q.fetch;
  assign vectorAddr   = q.vecAddr;

  a_lvd_pin_low: assert property (@(posedge clk) disable iff (sys_rst)
    !q.supplyOk |=> resetPinOe && cpuRst)
    else $error("supply drop did not drive reset pin");
  a_hyst_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (q.supplyOk && supplyAboveFall && !supplyAboveRise) |=> q.supplyOk)
    else $error("supply ok dropped above falling threshold");
  a_pin_hold_min: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(resetPinOe) |-> resetPinOe[*8])
    else $error("reset pin released too early");
  a_stab_full: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(vectorFetch) |-> $past(q.cnt) == rscg_pkg::STAB_LAST
                           && $past(q.phase) == rscg_pkg::PH_STAB)
    else $error("fetch began before stabilisation count ended");
  a_fetch_two: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(vectorFetch) |-> vectorAddr == rscg_pkg::VEC_ADDR_LO
      ##1 (vectorFetch && vectorAddr == rscg_pkg::VEC_ADDR_HI) ##1 !vectorFetch)
    else $error("vector fetch not two cycles");
  a_cpu_release: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(cpuRst) |-> vectorFetch)
    else $error("internal reset released outside fetch");
  a_wdg_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    wdgUnderflow |=> q.wdgFlag && resetPinOe)
    else $error("watchdog reset not recorded");
  a_lvd_flag_keep: assert property (@(posedge clk) disable iff (sys_rst)
    (q.lvdFlag && !(apbDone && pwrite && is_reg(paddr, rscg_pkg::REG_FLAGS)))
      |=> q.lvdFlag)
    else $error("supply drop flag lost");
  a_src_restart: assert property (@(posedge clk) disable iff (sys_rst)
    anySrc |=> q.phase == rscg_pkg::PH_DELAY && q.cnt == 12'h000)
    else $error("reset source did not restart sequence");
endmodule // reset_sequence_clock_guard

// ### verification/rscg_ext_rst.sv
// board-side model of the reset line: weak pull-up plus external pull-down
module rscg_ext_rst (
  // clock
  input  wire logic        clk,
  // pull request from the bench
  input  wire logic        pullStart,
  input  wire logic [11:0] pullLen,
  // reset pin
  input  wire logic        resetPinOe,
  output logic             resetPinWire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] pullCnt_q = 12'h000;
  // holds the line low for the commanded width
  always @(posedge clk) begin
    if (pullStart) begin
      pullCnt_q <= pullLen;
    end else if (pullCnt_q != 12'h000) begin
      pullCnt_q <= pullCnt_q - 12'h001;
    end
  end
  // low if anyone pulls, else the pull-up wins
  assign resetPinWire = !(resetPinOe || pullCnt_q != 12'h000);
endmodule // rscg_ext_rst

// ### verification/reset_sequence_clock_guard_bench.sv
// self-checking bench of the reset sequencer and clock guard
module reset_sequence_clock_guard_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 50000;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, ev;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv, wdata;
  logic        resetPinIn, resetPinOut, resetPinOe, pullStart = 1'b0;
  logic [11:0] pullLen = 12'h000;
  logic        supplyAboveRise = 1'b1, supplyAboveFall = 1'b1;
  logic [1:0]  thresholdSel, optThreshold = 2'h0;
  logic [2:0]  optOscSource = 3'h0, oscSelect, gap = 3'h0;
  logic        optGuardEn = 1'b0, wdgUnderflow = 1'b0, oscEdge = 1'b0;
  logic        edgeOn = 1'b1, spikeOn = 1'b0;
  logic        oscRun, blockMain, backupClkSel, cpuRst, vectorFetch;
  logic [15:0] vectorAddr;
  int          seed = 32'h5165c6f3, nMismatch = 0, checksDone = 0, cyc = 0;

  always #12.5 clk = ~clk;

  reset_sequence_clock_guard dut_u (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .supplyAboveRise(supplyAboveRise), .supplyAboveFall(supplyAboveFall),
    .thresholdSel(thresholdSel), .optThreshold(optThreshold),
    .optOscSource(optOscSource), .optGuardEn(optGuardEn),
    .wdgUnderflow(wdgUnderflow), .oscEdge(oscEdge), .oscSelect(oscSelect),
    .oscRun(oscRun), .blockMain(blockMain), .backupClkSel(backupClkSel),
    .cpuRst(cpuRst), .vectorFetch(vectorFetch), .vectorAddr(vectorAddr)
  );

  rscg_ext_rst ext_u (
    .clk(clk), .pullStart(pullStart), .pullLen(pullLen),
    .resetPinOe(resetPinOe), .resetPinWire(resetPinIn)
  );

  // oscillator edges: random periods of 3..6 cycles, or spikes every cycle
  always @(posedge clk) begin
    if (gap == 3'h0) begin
      oscEdge <= edgeOn;
      gap <= spikeOn ? 3'h0 : 3'h2 + 3'($unsigned($random(seed)) % 4);
    end else begin
      oscEdge <= 1'b0;
      gap <= gap - 3'h1;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      nMismatch++;
      test_done;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function logic [1:0] thrExp(input logic [1:0] v);
    return (v == 2'h3) ? 2'h2 : v;
  endfunction

  function logic [2:0] oscExp(input logic [2:0] v);
    return (v == 3'h7) ? 3'h6 : v;
  endfunction

  function logic [31:0] flagsExp(input logic supply_drop_detector, input logic bk, input logic wdg);
    return {27'h0, supply_drop_detector, 2'b00, bk, wdg};
  endfunction

  task tick;
    @(posedge clk);
    #1;
  endtask

  // one apb transfer; answer lands in rv and ev
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      tick;
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) nMismatch++;
    rv = prdata;
    ev = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task doReset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task pulseWdg;
    @(posedge clk);
    wdgUnderflow <= 1'b1;
    @(posedge clk);
    wdgUnderflow <= 1'b0;
  endtask

  task pullPin(input logic [11:0] len);
    @(posedge clk);
    pullStart <= 1'b1;
    pullLen <= len;
    @(posedge clk);
    pullStart <= 1'b0;
  endtask

  // follows one reset sequence: pin delay, stabilisation, vector fetch
  task seq(input int lo, input int hi);
    int n;
    #1;
    n = 0;
    while (resetPinOe !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    n = 0;
    while (resetPinOe === 1'b1 && n < 9000) begin
      tick;
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
    chk(cpuRst, 1'b1);
    n = 0;
    while (vectorFetch !== 1'b1 && n < 5000) begin
      tick;
      n++;
    end
    chk(n, rscg_pkg::STAB_CYC);
    chk({cpuRst, vectorAddr}, {1'b0, rscg_pkg::VEC_ADDR_LO});
    tick;
    chk({vectorFetch, vectorAddr}, {1'b1, rscg_pkg::VEC_ADDR_HI});
    tick;
    chk(vectorFetch, 1'b0);
  endtask

  initial begin
    for (int i = 0; i < 8; i++) begin
      optThreshold <= 2'(i);
      optOscSource <= 3'(i);
      doReset;
      #1;
      chk(thresholdSel, thrExp(2'(i)));
      chk(oscSelect, oscExp(3'(i)));
      chk(oscRun, 1'b1);
    end
    seq(790, 820);
    chk(resetPinOut, 1'b0);
    edgeOn <= 1'b0;
    repeat (60) tick;
    chk({blockMain, backupClkSel}, 2'b00);
    edgeOn <= 1'b1;
    apb(1'b0, rscg_pkg::REG_STATE, 32'h0);
    chk({ev, rv[10:8], rv[2:0]}, 7'h14);
    wdata = $random(seed);
    apb(1'b1, rscg_pkg::REG_FLAGS, wdata);
    apb(1'b0, rscg_pkg::REG_FLAGS, 32'h0);
    chk(rv, flagsExp(1'b0, 1'b0, 1'b0) | {29'h0, wdata[2], 2'b00});
    apb(1'b1, rscg_pkg::REG_FLAGS, 32'h11);
    apb(1'b0, 8'h08, 32'h0);
    chk({ev, rv[30:0]}, {1'b1, 31'h0});
    // watchdog reset
    pulseWdg;
    seq(800, 800);
    apb(1'b0, rscg_pkg::REG_FLAGS, 32'h0);
    chk(rv, flagsExp(1'b0, 1'b0, 1'b1));
    // supply dip with hysteresis
    supplyAboveRise <= 1'b0;
    apb(1'b0, rscg_pkg::REG_STATE, 32'h0);
    chk({rv[2], resetPinOe}, 2'b10);
    supplyAboveFall <= 1'b0;
    repeat (10) tick;
    chk({resetPinOe, cpuRst, oscRun}, 3'b111);
    supplyAboveFall <= 1'b1;
    apb(1'b0, rscg_pkg::REG_STATE, 32'h0);
    chk({rv[2], resetPinOe}, 2'b01);
    supplyAboveRise <= 1'b1;
    seq(790, 820);
    apb(1'b0, rscg_pkg::REG_FLAGS, 32'h0);
    chk(rv, flagsExp(1'b1, 1'b0, 1'b0));
    pulseWdg;
    seq(800, 800);
    apb(1'b0, rscg_pkg::REG_FLAGS, 32'h0);
    chk(rv, flagsExp(1'b1, 1'b0, 1'b1));
    apb(1'b1, rscg_pkg::REG_FLAGS, 32'h0);
    apb(1'b0, rscg_pkg::REG_FLAGS, 32'h0);
    chk(rv, flagsExp(1'b0, 1'b0, 1'b0));
    // external pin, short then long pulse
    pullPin(12'd6);
    seq(800, 800);
    apb(1'b0, rscg_pkg::REG_FLAGS, 32'h0);
    chk(rv, 32'h0);
    pullPin(12'd900);
    repeat (830) tick;
    chk(resetPinOe, 1'b1);
    seq(1, 900);
    // clock guard enabled
    optGuardEn <= 1'b1;
    doReset;
    repeat (200) tick;
    chk({blockMain, backupClkSel}, 2'b00);
    spikeOn <= 1'b1;
    repeat (7) tick;
    spikeOn <= 1'b0;
    repeat (2) tick;
    chk({blockMain, backupClkSel}, 2'b11);
    repeat (150) tick;
    chk({blockMain, backupClkSel}, 2'b00);
    edgeOn <= 1'b0;
    repeat (60) tick;
    apb(1'b0, rscg_pkg::REG_FLAGS, 32'h0);
    chk({backupClkSel, rv[1]}, 2'b11);
    edgeOn <= 1'b1;
    repeat (150) tick;
    chk(backupClkSel, 1'b0);
    test_done;
  end
endmodule // reset_sequence_clock_guard_bench
